// File: micro_insn_decode_regfile_tb_top.sv
// Self-checking bench for the microinstruction decoder
`timescale 1ns/1ns
module micro_insn_decode_regfile_tb_top;
    import mid_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] micro_insn_bus;
    logic mib_valid;
    logic indirect_condition_status = 1'b0;
    logic [15:0] internal_data_addr_lines = 16'hC3A5;
    logic [10:0] micro_addr;
    logic fetch_req;
    mid_flags_s status_flags;
    logic [7:0] port_a_data;
    logic [7:0] port_b_data;
    logic [2:0] base_reg;
    int n_fail = 0;
    int n_compared = 0;
    int n_cap = 0;
    int n_done = 0;
    int n_cyc = 0;
    logic [7:0] cyc;

    mid_decode dut (.ref_clk(ref_clk), .reset(reset), .micro_insn_bus(micro_insn_bus),
        .mib_valid(mib_valid), .indirect_condition_status(indirect_condition_status),
        .internal_data_addr_lines(internal_data_addr_lines), .micro_addr(micro_addr),
        .fetch_req(fetch_req), .status_flags(status_flags), .port_a_data(port_a_data),
        .port_b_data(port_b_data), .base_reg(base_reg));
    mid_cs_model cs (.ref_clk(ref_clk), .reset(reset), .fetch_req(fetch_req),
        .micro_addr(micro_addr), .micro_insn_bus(micro_insn_bus), .mib_valid(mib_valid));

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        if (!reset && fetch_req && mib_valid)
            n_cap <= n_cap + 1;
        n_cyc <= n_cyc + 1;
        if (n_cyc == 3000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8

    task automatic cmp11(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp11

    function automatic logic [7:0] fl();
        return {3'h0, status_flags.zb, status_flags.z, status_flags.n, status_flags.c,
            status_flags.v};
    endfunction : fl

    // Waits for one capture, then counts execute cycles until the next fetch
    task automatic step();
        int i;
        i = 0;
        do
        begin
            @(negedge ref_clk);
            i++;
        end
        while (n_cap == n_done && i < 50);
        n_done++;
        cyc = 8'h00;
        while (fetch_req !== 1'b1 && cyc < 8'h10)
        begin
            cyc++;
            @(negedge ref_clk);
        end
    endtask : step

    task automatic load_prog();
        cs.mem[0] = 16'h25A2;
        cs.mem[1] = 16'h2C33;
        cs.mem[2] = 16'h8724;
        cs.mem[3] = 16'h8132;
        cs.mem[4] = 16'h8233;
        cs.mem[5] = 16'h8F46;
        cs.mem[6] = 16'h3060;
        cs.mem[7] = 16'h2770;
        cs.mem[8] = 16'h87C4;
        cs.mem[9] = 16'h2661;
        cs.mem[10] = 16'h8714;
        cs.mem[11] = 16'h400A;
        cs.mem[12] = 16'h87B4;
        cs.mem[13] = 16'h05F0;
        cs.mem[11'h5F0] = 16'h0800;
        cs.mem[14] = 16'h0600;
        cs.mem[11'h600] = 16'h1340;
        cs.mem[11'h640] = 16'h1340;
        cs.mem[11'h641] = 16'h1B80;
    endtask : load_prog

    task automatic t_reset();
        @(negedge ref_clk);
        cmp11(micro_addr, 11'h000);
        cmp8({7'h00, fetch_req}, 8'h01);
        cmp8(fl(), 8'h00);
        cmp8(port_b_data, 8'h00);
        cmp8({5'h00, base_reg}, 8'h00);
    endtask : t_reset

    task automatic t_byte();
        step();
        cmp8(cyc, 8'h01);
        step();
        step();
        cmp8(cyc, 8'h01);
        cmp8(port_b_data, 8'h5A);
        step();
        cmp8(fl(), 8'h02);
        cmp11(micro_addr, 11'h004);
    endtask : t_byte

    task automatic t_cc_keep();
        step();
        cmp8(fl(), 8'h12);
        cmp8(status_flags, 8'hB2);
        cmp8(port_b_data, 8'hC3);
        cmp8(port_a_data, 8'hC3);
    endtask : t_cc_keep

    task automatic t_word();
        cs.lat = 2;
        step();
        cmp8(cyc, 8'h02);
        cmp8(port_b_data, 8'h00);
        cmp8(fl(), 8'h02);
    endtask : t_word

    task automatic t_indirect();
        step();
        cmp8({5'h00, base_reg}, 8'h06);
        step();
        step();
        cmp8(port_b_data, 8'h77);
        step();
        step();
        cmp8(port_b_data, 8'h66);
    endtask : t_indirect

    task automatic t_input_word();
        step();
        cmp8({5'h00, base_reg}, 8'h05);
        step();
        cmp8(port_b_data, 8'hC3);
        cmp8({5'h00, base_reg}, 8'h05);
    endtask : t_input_word

    task automatic t_jumps();
        step();
        cmp11(micro_addr, 11'h5F0);
        step();
        cmp11(micro_addr, 11'h00E);
        @(posedge ref_clk);
        #2;
        indirect_condition_status = 1'b1;
        step();
        cmp11(micro_addr, 11'h600);
        step();
        cmp11(micro_addr, 11'h640);
        @(posedge ref_clk);
        #2;
        indirect_condition_status = 1'b0;
        step();
        cmp11(micro_addr, 11'h641);
        step();
        cmp11(micro_addr, 11'h680);
    endtask : t_jumps

    initial
    begin
        load_prog();
        repeat (20) @(posedge ref_clk);
        #2;
        reset = 1'b0;
        t_reset();
        t_byte();
        t_cc_keep();
        t_word();
        t_indirect();
        t_input_word();
        t_jumps();
        stop_test();
    end
endmodule : micro_insn_decode_regfile_tb_top

// File: mid_cs_model.sv
// Control store model that answers fetch requests from the decoder
`timescale 1ns/1ns
module mid_cs_model
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic fetch_req,
    input wire logic [10:0] micro_addr,
    output logic [15:0] micro_insn_bus,
    output logic mib_valid
);
    logic [15:0] mem [0:2047] = '{default: 16'h5000};
    int lat = 0;
    int cnt = 0;

    initial
    begin
        micro_insn_bus = 16'h0000;
        mib_valid = 1'b0;
    end

    // Word is held until taken; the bus toggles while nothing is offered
    always @(posedge ref_clk)
    begin
        #1;
        if (!reset && fetch_req && cnt >= lat)
        begin
            micro_insn_bus = mem[micro_addr];
            mib_valid = 1'b1;
        end
        else
        begin
            cnt = fetch_req ? cnt + 1 : 0;
            micro_insn_bus = ~micro_insn_bus;
            mib_valid = 1'b0;
        end
    end
endmodule : mid_cs_model

// File: mid_decode.sv
// Microinstruction register, decoder, sequencer and byte register file
`timescale 1ns/1ns
`include "mid_regs.svh"
module mid_decode
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] micro_insn_bus,
    input wire logic mib_valid,
    input wire logic indirect_condition_status,
    input wire logic [15:0] internal_data_addr_lines,
    output logic [10:0] micro_addr,
    output logic fetch_req,
    output mid_pkg::mid_flags_s status_flags,
    output logic [7:0] port_a_data,
    output logic [7:0] port_b_data,
    output logic [2:0] base_reg
);
    import mid_pkg::*;

    mid_state_s s_r;
    mid_state_s s_nxt;
    logic [3:0] op;
    logic [1:0] fn;
    logic inv;
    logic word;
    logic last;
    logic [4:0] ia;
    logic [4:0] ib;
    logic [7:0] a_op;
    logic [7:0] b_op;
    logic cin;
    logic [9:0] alu;
    logic wz;
    logic [7:0] cond_vec;
    logic cond_ok;

    // Map a 4-bit field to a physical byte; SP and PC bytes are shared
    function automatic logic [4:0] mid_rf_index(input logic [3:0] f,
                                                input logic [2:0] g,
                                                input logic flip);
        logic [3:0] a;
        a = (f[3:1] == 3'h0) ? {g, f[0]} : f;
        a[0] = a[0] ^ flip;
        if (f[3:1] == 3'h0 || a >= `MID_DIRECT_SPLIT)
        begin
            return {1'b0, a};
        end
        return {1'b0, a} + `MID_DIRECT_BIAS;
    endfunction : mid_rf_index

    // Byte ALU: {half carry, carry out, result}
    function automatic logic [9:0] mid_alu(input logic [1:0] f,
                                           input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic ci);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        bb = (f == `MID_FN_SUB) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        case (f)
            `MID_FN_AND: s = {1'b0, a & b};
            `MID_FN_MOV: s = {1'b0, b};
            default: s = s;
        endcase
        return {h[4], s};
    endfunction : mid_alu

    always_comb
    begin
        s_nxt = s_r;
        op = s_r.micro_insn_register[`MID_OPC_HI:`MID_OPC_LO];
        fn = s_r.micro_insn_register[`MID_FN_HI:`MID_FN_LO];
        word = s_r.micro_insn_register[`MID_WORD_BIT];
        inv = (s_r.st == MID_WORD2);
        last = inv || !word;
        ia = mid_rf_index(s_r.micro_insn_register[`MID_A_HI:0], s_r.g, inv);
        ib = mid_rf_index(s_r.micro_insn_register[`MID_B_HI:`MID_B_LO], s_r.g, inv);
        a_op = s_r.rf[ia];
        b_op = s_r.rf[ib];
        // High byte chains the low byte's carry
        cin = inv ? s_r.flags.cb : (fn == `MID_FN_SUB);
        alu = mid_alu(fn, a_op, b_op, cin);
        wz = (alu[7:0] == 8'h00) && (!inv || s_r.lo_zero);
        cond_vec = {s_r.flags.v, s_r.flags.c, s_r.flags.n, s_r.flags.z,
                    indirect_condition_status, s_r.flags.cb, s_r.flags.nb,
                    s_r.flags.zb};
        cond_ok = cond_vec[s_r.micro_insn_register[`MID_CSEL_HI:`MID_CSEL_LO]]
                  ^ s_r.micro_insn_register[`MID_CINV_BIT];
        case (s_r.st)
            MID_FETCH:
            begin
                if (mib_valid)
                begin
                    s_nxt.micro_insn_register = micro_insn_bus;
                    s_nxt.pc = s_r.pc + `MID_PC_STEP;
                    s_nxt.st = MID_EXEC;
                end
            end
            MID_EXEC, MID_WORD2:
            begin
                s_nxt.st = MID_FETCH;
                s_nxt.a_data = a_op;
                s_nxt.b_data = b_op;
                if (s_r.micro_insn_register[`MID_REGFMT_BIT])
                begin
                    s_nxt.rf[ia] = alu[7:0];
                    s_nxt.flags.zb = wz;
                    s_nxt.flags.nb = alu[7];
                    s_nxt.flags.cb = alu[8];
                    s_nxt.flags.c4 = alu[9];
                    if (!last)
                    begin
                        s_nxt.lo_zero = (alu[7:0] == 8'h00);
                        s_nxt.st = MID_WORD2;
                    end
                    else if (s_r.micro_insn_register[`MID_CCUPD_BIT])
                    begin
                        // Odd opcode only; even opcodes leave codes alone
                        s_nxt.flags.z = wz;
                        s_nxt.flags.n = alu[7];
                        if (fn == `MID_FN_ADD || fn == `MID_FN_SUB)
                        begin
                            s_nxt.flags.c = (fn == `MID_FN_SUB) ? !alu[8] : alu[8];
                            s_nxt.flags.v = (a_op[7] == (b_op[7] ^ fn[0]))
                                            && (alu[7] != a_op[7]);
                        end
                        else
                        begin
                            s_nxt.flags.v = 1'b0;
                        end
                    end
                end
                else if (inv)
                begin
                    s_nxt.rf[ia] = s_r.hold;
                end
                else
                begin
                    case (op)
                        `MID_OP_JUMP:
                        begin
                            if (s_r.micro_insn_register[`MID_RFS_BIT])
                            begin
                                s_nxt.pc = s_r.ret;
                            end
                            else
                            begin
                                s_nxt.ret = s_r.pc;
                                s_nxt.pc = s_r.micro_insn_register[`MID_JTGT_HI:0];
                            end
                        end
                        `MID_OP_CJUMP:
                        begin
                            if (cond_ok)
                            begin
                                s_nxt.pc = {s_r.pc[10:8], s_r.micro_insn_register[`MID_CTGT_HI:0]};
                            end
                        end
                        `MID_OP_LIT:
                        begin
                            s_nxt.rf[ia] = s_r.micro_insn_register[`MID_LIT_HI:`MID_LIT_LO];
                        end
                        `MID_OP_LDBASE:
                        begin
                            s_nxt.g = s_r.micro_insn_register[`MID_LIT_LO+2:`MID_LIT_LO];
                        end
                        `MID_OP_INWORD:
                        begin
                            s_nxt.rf[ia] = internal_data_addr_lines[7:0];
                            s_nxt.hold = internal_data_addr_lines[15:8];
                            s_nxt.g = internal_data_addr_lines[2:0];
                            s_nxt.st = MID_WORD2;
                        end
                        default:
                        begin
                            s_nxt.st = MID_FETCH;
                        end
                    endcase
                end
            end
            default:
            begin
                s_nxt.st = MID_FETCH;
            end
        endcase
        s_nxt.fetch = (s_nxt.st == MID_FETCH);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            s_r <= '0;
            s_r.st <= MID_FETCH;
            s_r.fetch <= 1'b1;
            s_r.pc <= `MID_PC_RESET;
            s_r.g <= `MID_G_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign micro_addr = s_r.pc;
    assign fetch_req = s_r.fetch;
    assign status_flags = s_r.flags;
    assign port_a_data = s_r.a_data;
    assign port_b_data = s_r.b_data;
    assign base_reg = s_r.g;

    logic ex;
    logic ex_reg;
    assign ex = (s_r.st == MID_EXEC);
    assign ex_reg = ex && s_r.micro_insn_register[`MID_REGFMT_BIT];

    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    jump_target_a: assert property (
        ex && !ex_reg && op == `MID_OP_JUMP && !s_r.micro_insn_register[`MID_RFS_BIT]
        |=> s_r.pc == $past(s_r.micro_insn_register[10:0]) && s_r.ret == $past(s_r.pc))
        else $error("jump did not load target");
    return_path_a: assert property (
        ex && !ex_reg && op == `MID_OP_JUMP && s_r.micro_insn_register[`MID_RFS_BIT]
        |=> s_r.pc == $past(s_r.ret) && $stable(s_r.ret))
        else $error("return did not use saved location");
    return_save_a: assert property (
        $changed(s_r.ret) |-> $past(ex && op == `MID_OP_JUMP && !s_r.micro_insn_register[15]))
        else $error("return location changed outside a jump");
    cjump_miss_a: assert property (
        ex && !ex_reg && op == `MID_OP_CJUMP && !cond_ok |=> $stable(s_r.pc))
        else $error("failed test still transferred");
    cjump_page_a: assert property (
        ex && !ex_reg && op == `MID_OP_CJUMP && cond_ok
        |=> s_r.pc == {$past(s_r.pc[10:8]), $past(s_r.micro_insn_register[7:0])})
        else $error("taken jump left the page");
    byte_cycle_a: assert property (
        ex_reg && !word |=> s_r.st == MID_FETCH)
        else $error("byte operation took extra cycle");
    word_cycle_a: assert property (
        ex_reg && word |=> s_r.st == MID_WORD2 ##1 s_r.st == MID_FETCH)
        else $error("word operation not two cycles");
    base_load_a: assert property (
        $changed(s_r.g) |-> $past(ex && !s_r.micro_insn_register[15]
            && (op == `MID_OP_LDBASE || op == `MID_OP_INWORD)))
        else $error("base register changed without a load");
    even_keep_a: assert property (
        ex_reg && !word && !s_r.micro_insn_register[`MID_CCUPD_BIT]
        |=> s_r.flags[3:0] == $past(s_r.flags[3:0]))
        else $error("even opcode altered condition codes");
    mir_hold_a: assert property (
        s_r.st != MID_FETCH |=> $stable(s_r.micro_insn_register) || $past(s_r.st) == MID_FETCH)
        else $error("instruction register changed mid-execution");

    word_op_c: cover property (ex_reg && word ##2 s_r.st == MID_FETCH);
    cjump_taken_c: cover property (ex && op == `MID_OP_CJUMP && !s_r.micro_insn_register[15] && cond_ok);
    call_return_c: cover property (ex && op == `MID_OP_JUMP && !s_r.micro_insn_register[15]
        && s_r.micro_insn_register[`MID_RFS_BIT]);
    indirect_c: cover property (ex_reg && s_r.micro_insn_register[3:1] == 3'h0 && s_r.micro_insn_register[7:5] == 3'h0);
endmodule : mid_decode

// File: mid_pkg.sv
// Types shared by the microinstruction decoder
`include "mid_regs.svh"
package mid_pkg;
    typedef enum logic [1:0] {MID_FETCH, MID_EXEC, MID_WORD2} mid_state_e;
    typedef struct packed {
        logic zb;
        logic nb;
        logic cb;
        logic c4;
        logic z;
        logic n;
        logic c;
        logic v;
    } mid_flags_s;
    typedef struct packed {
        mid_state_e st;
        logic fetch;
        logic [10:0] pc;
        logic [10:0] ret;
        logic [15:0] micro_insn_register;
        logic [2:0] g;
        logic [`MID_RF_SIZE-1:0][7:0] rf;
        mid_flags_s flags;
        logic lo_zero;
        logic [7:0] hold;
        logic [7:0] a_data;
        logic [7:0] b_data;
    } mid_state_s;
endpackage : mid_pkg

// File: mid_regs.svh
// Microinstruction field positions, opcodes and reset values
`ifndef MID_REGS_SVH
`define MID_REGS_SVH
`define MID_OPC_HI 15
`define MID_OPC_LO 12
`define MID_OP_JUMP 4'h0
`define MID_OP_CJUMP 4'h1
`define MID_OP_LIT 4'h2
`define MID_OP_LDBASE 4'h3
`define MID_OP_INWORD 4'h4
`define MID_REGFMT_BIT 15
`define MID_RFS_BIT 11
`define MID_JTGT_HI 10
`define MID_CINV_BIT 11
`define MID_CSEL_HI 10
`define MID_CSEL_LO 8
`define MID_CTGT_HI 7
`define MID_LIT_HI 11
`define MID_LIT_LO 4
`define MID_WORD_BIT 11
`define MID_FN_HI 10
`define MID_FN_LO 9
`define MID_CCUPD_BIT 8
`define MID_B_HI 7
`define MID_B_LO 4
`define MID_A_HI 3
`define MID_FN_ADD 2'h0
`define MID_FN_SUB 2'h1
`define MID_FN_AND 2'h2
`define MID_FN_MOV 2'h3
`define MID_RF_SIZE 26
`define MID_DIRECT_SPLIT 4'hC
`define MID_DIRECT_BIAS 5'h0E
`define MID_PC_RESET 11'h000
`define MID_G_RESET 3'h0
`define MID_PC_STEP 11'h001
`endif
